// ===== lrc_regs.sv
// control register bank for linear regulators seven, eight and nine
// How it works
// - bit 7 holds the on/off state the sequencer copies into bit 0 when it runs and bits 2:1 are 00.
// - a pin named in bits 6:5 selects preset a on its rise and preset b on its fall, once the edge is past the two-flop synchroniser.
// - pin fields decode 00 no pin (sequencer in bits 2:1), 01 pin 1, 10 pin 2, 11 pin 13.
// - bit 4 picks the output voltage directly, 0 preset a and 1 preset b.
// - bit 3 at 0 connects the output pull-down while off, at 1 leaves it open.
// - a pin named in bits 2:1 turns the regulator on at its rise and off at its fall.
// - bit 0 is the live on/off state of the regulator.
`default_nettype none
module lrc_regs
  import lrc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // sequencer strobe, same clock
  input wire logic seq_apply,
  // general-purpose pins gp1, gp2, gp13, asynchronous
  input wire logic [2:0] gp_pins,
  // regulator controls
  output logic [2:0] reg_on,
  output logic [2:0] reg_vsel,
  output logic [2:0] reg_pulldown_en
);
  // pin synchroniser and edge history
  logic [2:0] meta_r;
  logic [2:0] meta_nxt;
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic [2:0] prev_r;
  logic [2:0] prev_nxt;
  logic [2:0] rise;
  logic [2:0] fall;

  // address decode
  logic [LRC_NUM_REGS-1:0] sel;
  logic [LRC_NUM_REGS-1:0] wr_sel;
  logic addr_hit;

  // stored contents and read data
  logic [7:0] ctrl [LRC_NUM_REGS];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // field views of regulator seven
  logic reg_seven_seq_target;
  logic [1:0] reg_seven_vsel_pin;
  logic reg_seven_vsel;
  logic reg_seven_pulldown_off;
  logic [1:0] reg_seven_enable_pin;
  logic reg_seven_on;

  // field views of regulator eight
  logic reg_eight_seq_target;
  logic [1:0] reg_eight_vsel_pin;
  logic reg_eight_vsel;
  logic reg_eight_pulldown_off;
  logic [1:0] reg_eight_enable_pin;
  logic reg_eight_on;

  // field views of regulator nine
  logic reg_nine_seq_target;
  logic [1:0] reg_nine_vsel_pin;
  logic reg_nine_vsel;
  logic reg_nine_pulldown_off;
  logic [1:0] reg_nine_enable_pin;
  logic reg_nine_on;

  // two flops before any logic reads a pin
  always_comb begin
    meta_nxt = gp_pins;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  // one-cycle pulses on each settled pin edge
  always_comb begin
    rise = sync_r & ~prev_r;
    fall = ~sync_r & prev_r;
  end

  // history clears to the idle low level, so no false edge after reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 3'h0;
      sync_r <= 3'h0;
      prev_r <= 3'h0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  // one-hot select; unmapped addresses select nothing
  always_comb begin
    sel = '0;
    unique case (reg_addr)
      LRC_OFS_REG7: sel = 3'h1;
      LRC_OFS_REG8: sel = 3'h2;
      LRC_OFS_REG9: sel = 3'h4;
      default: sel = '0;
    endcase
    addr_hit = |sel;
    // writes reach only the selected register
    wr_sel = reg_wr ? sel : '0;
  end

  // one register per regulator
  for (genvar i = 0; i < LRC_NUM_REGS; i++) begin : g_ch
    lrc_channel u_ch (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .wr_en(wr_sel[i]),
      .wr_data(reg_wdata),
      .seq_apply(seq_apply),
      .pins_rise(rise),
      .pins_fall(fall),
      .ctrl(ctrl[i])
    );
  end

  // regulator seven fields
  always_comb begin
    reg_seven_seq_target = ctrl[0][LRC_BIT_SEQ_TARGET];
    reg_seven_vsel_pin = ctrl[0][LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO];
    reg_seven_vsel = ctrl[0][LRC_BIT_VSEL];
    reg_seven_pulldown_off = ctrl[0][LRC_BIT_PULLDOWN_OFF];
    reg_seven_enable_pin = ctrl[0][LRC_EN_PIN_HI:LRC_EN_PIN_LO];
    reg_seven_on = ctrl[0][LRC_BIT_ON];
  end

  // regulator eight fields
  always_comb begin
    reg_eight_seq_target = ctrl[1][LRC_BIT_SEQ_TARGET];
    reg_eight_vsel_pin = ctrl[1][LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO];
    reg_eight_vsel = ctrl[1][LRC_BIT_VSEL];
    reg_eight_pulldown_off = ctrl[1][LRC_BIT_PULLDOWN_OFF];
    reg_eight_enable_pin = ctrl[1][LRC_EN_PIN_HI:LRC_EN_PIN_LO];
    reg_eight_on = ctrl[1][LRC_BIT_ON];
  end

  // regulator nine fields
  always_comb begin
    reg_nine_seq_target = ctrl[2][LRC_BIT_SEQ_TARGET];
    reg_nine_vsel_pin = ctrl[2][LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO];
    reg_nine_vsel = ctrl[2][LRC_BIT_VSEL];
    reg_nine_pulldown_off = ctrl[2][LRC_BIT_PULLDOWN_OFF];
    reg_nine_enable_pin = ctrl[2][LRC_EN_PIN_HI:LRC_EN_PIN_LO];
    reg_nine_on = ctrl[2][LRC_BIT_ON];
  end

  // live on/off state per regulator
  assign reg_on[0] = reg_seven_on;
  assign reg_on[1] = reg_eight_on;
  assign reg_on[2] = reg_nine_on;

  // voltage preset choice per regulator
  assign reg_vsel[0] = reg_seven_vsel;
  assign reg_vsel[1] = reg_eight_vsel;
  assign reg_vsel[2] = reg_nine_vsel;

  // pull-down only while the regulator is off
  assign reg_pulldown_en[0] = ~reg_seven_on & ~reg_seven_pulldown_off;
  assign reg_pulldown_en[1] = ~reg_eight_on & ~reg_eight_pulldown_off;
  assign reg_pulldown_en[2] = ~reg_nine_on & ~reg_nine_pulldown_off;

  // readback rebuilt field by field
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_rd && addr_hit) begin
      unique case (reg_addr)
        // regulator seven
        LRC_OFS_REG7: begin
          rdata_nxt[LRC_BIT_SEQ_TARGET] = reg_seven_seq_target;
          rdata_nxt[LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO] = reg_seven_vsel_pin;
          rdata_nxt[LRC_BIT_VSEL] = reg_seven_vsel;
          rdata_nxt[LRC_BIT_PULLDOWN_OFF] = reg_seven_pulldown_off;
          rdata_nxt[LRC_EN_PIN_HI:LRC_EN_PIN_LO] = reg_seven_enable_pin;
          rdata_nxt[LRC_BIT_ON] = reg_seven_on;
        end

        // regulator eight
        LRC_OFS_REG8: begin
          rdata_nxt[LRC_BIT_SEQ_TARGET] = reg_eight_seq_target;
          rdata_nxt[LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO] = reg_eight_vsel_pin;
          rdata_nxt[LRC_BIT_VSEL] = reg_eight_vsel;
          rdata_nxt[LRC_BIT_PULLDOWN_OFF] = reg_eight_pulldown_off;
          rdata_nxt[LRC_EN_PIN_HI:LRC_EN_PIN_LO] = reg_eight_enable_pin;
          rdata_nxt[LRC_BIT_ON] = reg_eight_on;
        end

        // regulator nine
        LRC_OFS_REG9: begin
          rdata_nxt[LRC_BIT_SEQ_TARGET] = reg_nine_seq_target;
          rdata_nxt[LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO] = reg_nine_vsel_pin;
          rdata_nxt[LRC_BIT_VSEL] = reg_nine_vsel;
          rdata_nxt[LRC_BIT_PULLDOWN_OFF] = reg_nine_pulldown_off;
          rdata_nxt[LRC_EN_PIN_HI:LRC_EN_PIN_LO] = reg_nine_enable_pin;
          rdata_nxt[LRC_BIT_ON] = reg_nine_on;
        end
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // read data stand one cycle, zero otherwise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// ===== lrc_pkg.sv
// package for the linear regulator control register bank
`default_nettype none
package lrc_pkg;
  localparam int LRC_NUM_REGS = 3;
  localparam int LRC_ADDR_W = 8;
  localparam int LRC_DATA_W = 8;
  localparam logic [7:0] LRC_OFS_REG7 = 8'h2c;
  localparam logic [7:0] LRC_OFS_REG8 = 8'h2d;
  localparam logic [7:0] LRC_OFS_REG9 = 8'h2e;
  localparam int LRC_BIT_SEQ_TARGET = 7;
  localparam int LRC_VSEL_PIN_HI = 6;
  localparam int LRC_VSEL_PIN_LO = 5;
  localparam int LRC_BIT_VSEL = 4;
  localparam int LRC_BIT_PULLDOWN_OFF = 3;
  localparam int LRC_EN_PIN_HI = 2;
  localparam int LRC_EN_PIN_LO = 1;
  localparam int LRC_BIT_ON = 0;
  localparam logic [7:0] LRC_REG_RESET = 8'h00;
  localparam logic [1:0] LRC_PIN_NONE = 2'h0;
  localparam logic [1:0] LRC_PIN_GP1 = 2'h1;
  localparam logic [1:0] LRC_PIN_GP2 = 2'h2;
  localparam logic [1:0] LRC_PIN_GP13 = 2'h3;
endpackage
`default_nettype wire

// ===== lrc_channel.sv
// one regulator control register with pin and sequencer updates
`default_nettype none
module lrc_channel
  import lrc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // software write
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  // sequencer
  input wire logic seq_apply,
  // pin edge pulses: gp1, gp2, gp13
  input wire logic [2:0] pins_rise,
  input wire logic [2:0] pins_fall,
  // register contents
  output logic [7:0] ctrl
);
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic en_rise, en_fall, vs_rise, vs_fall;

  function automatic logic pick(input logic [1:0] sel, input logic [2:0] v);
    logic r;
    r = 1'b0;
    unique case (sel)
      LRC_PIN_NONE: r = 1'b0;
      LRC_PIN_GP1: r = v[0];
      LRC_PIN_GP2: r = v[1];
      LRC_PIN_GP13: r = v[2];
    endcase
    return r;
  endfunction

  always_comb begin
    en_rise = pick(ctrl_r[LRC_EN_PIN_HI:LRC_EN_PIN_LO], pins_rise);
    en_fall = pick(ctrl_r[LRC_EN_PIN_HI:LRC_EN_PIN_LO], pins_fall);
    vs_rise = pick(ctrl_r[LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO], pins_rise);
    vs_fall = pick(ctrl_r[LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO], pins_fall);
    ctrl_nxt = ctrl_r;
    if (wr_en) begin
      ctrl_nxt = wr_data;
    end
    // sequencer: only when on/off is not pin controlled
    if (seq_apply && ctrl_nxt[LRC_EN_PIN_HI:LRC_EN_PIN_LO] == LRC_PIN_NONE) begin
      ctrl_nxt[LRC_BIT_ON] = ctrl_nxt[LRC_BIT_SEQ_TARGET];
    end
    // pin events win over a same-cycle write
    if (en_rise) begin
      ctrl_nxt[LRC_BIT_ON] = 1'b1;
    end else if (en_fall) begin
      ctrl_nxt[LRC_BIT_ON] = 1'b0;
    end
    if (vs_rise) begin
      ctrl_nxt[LRC_BIT_VSEL] = 1'b0;
    end else if (vs_fall) begin
      ctrl_nxt[LRC_BIT_VSEL] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= LRC_REG_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign ctrl = ctrl_r;
endmodule
`default_nettype wire

// ===== lrc_regs_chk.sv
// assertions for the regulator control register bank
`default_nettype none
module lrc_regs_chk
  import lrc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // sequencer and pins
  input wire logic seq_apply,
  input wire logic [2:0] gp_pins,
  // regulator controls
  input wire logic [2:0] reg_on,
  input wire logic [2:0] reg_vsel,
  input wire logic [2:0] reg_pulldown_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic w7;
  // write to regulator seven with neither pin field set and no sequencer pulse
  assign w7 = reg_wr && !seq_apply && reg_addr == LRC_OFS_REG7
    && reg_wdata[LRC_VSEL_PIN_HI:LRC_VSEL_PIN_LO] == LRC_PIN_NONE
    && reg_wdata[LRC_EN_PIN_HI:LRC_EN_PIN_LO] == LRC_PIN_NONE;
  a_on_no_pd: assert property (reg_on[0] |-> !reg_pulldown_en[0]) else $error("pd");
  a_wr_on: assert property (w7 |=> reg_on[0] == $past(reg_wdata[0])) else $error("on");
  a_wr_vsel: assert property (w7 |=> reg_vsel[0] == $past(reg_wdata[4])) else $error("vs");
  a_wr_pd: assert property (w7 |=> reg_pulldown_en[0] == ($past(reg_wdata[3:0]) == 4'h0))
    else $error("pdw");
  a_seq_copy: assert property (reg_wr && reg_addr == 8'h2e && reg_wdata == 8'h80 ##1
    seq_apply && !reg_wr |=> reg_on[2]) else $error("seq");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h0) else $error("idle");
  a_rd_unmap: assert property (reg_rd && !(reg_addr inside {[8'h2c:8'h2e]}) |=>
    reg_rdata == 8'h0) else $error("unmap");
  a_rd_live: assert property (reg_rd && reg_addr == 8'h2d |=> reg_rdata[0] == $past(reg_on[1])
    && reg_rdata[4] == $past(reg_vsel[1])) else $error("rd");
  c_seq: cover property (seq_apply);
  c_pin: cover property ($rose(gp_pins[2]));
  c_rd: cover property (reg_rd ##1 reg_rdata != 8'h0);
endmodule
bind lrc_regs lrc_regs_chk i_chk (
  .clk_sys(clk_sys),
  .rstn(rstn),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .seq_apply(seq_apply),
  .gp_pins(gp_pins),
  .reg_on(reg_on),
  .reg_vsel(reg_vsel),
  .reg_pulldown_en(reg_pulldown_en)
);
`default_nettype wire

// ===== test_lrc_regs.sv
// bench for the regulator control register bank
`default_nettype none
module test_lrc_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, seq_apply = 0;
  logic [7:0] reg_addr = 8'h0, reg_wdata = 8'h0, reg_rdata;
  logic [2:0] gp_pins = 3'h0, reg_on, reg_vsel, reg_pulldown_en;
  int n_mismatch = 0, checks_done = 0;
  always #5 clk_sys = ~clk_sys;
  lrc_regs i_dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .seq_apply(seq_apply),
    .gp_pins(gp_pins),
    .reg_on(reg_on),
    .reg_vsel(reg_vsel),
    .reg_pulldown_en(reg_pulldown_en)
  );
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] outs(int i);
    return {5'h0, reg_on[i], reg_vsel[i], reg_pulldown_en[i]};
  endfunction
  // write, optionally followed at once by a sequencer pulse
  task automatic wr(logic [7:0] a, logic [7:0] d, logic s = 0);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
    seq_apply <= s;
    @(posedge clk_sys);
    seq_apply <= 0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  task automatic t_rw;
    for (int a = 8'h2c; a < 8'h2f; a++) rd(8'(a), 8'h0);
    wr(8'h2c, 8'h19);
    chk("reg7", 8'h06, outs(0));
    wr(8'h2c, 8'h00);
    chk("reg7", 8'h01, outs(0));
    wr(8'h2d, 8'h99);
    chk("reg8", 8'h06, outs(1));
    rd(8'h2d, 8'h99);
    wr(8'h2f, 8'hff);
    rd(8'h2f, 8'h00);
    $display("rw end");
  endtask
  task automatic t_seq;
    wr(8'h2e, 8'h80, 1);
    chk("seq on", 8'h04, outs(2));
    wr(8'h2e, 8'h82, 1);
    chk("seq held", 8'h01, outs(2));
    rd(8'h2e, 8'h82);
    $display("seq end");
  endtask
  task automatic t_pin;
    int p;
    for (int c = 0; c < 4; c++) begin
      p = (c + 2) % 3;
      wr(8'h2d, {1'b0, 2'(c), 2'h2, 2'(c), 1'b0});
      @(posedge clk_sys) gp_pins[p] <= 1'b1;
      repeat (5) @(posedge clk_sys);
      #1 chk("rise", {6'h0, c != 0, c == 0}, outs(1) >> 1);
      @(posedge clk_sys) gp_pins[p] <= 1'b0;
      repeat (5) @(posedge clk_sys);
      #1 chk("fall", 8'h01, outs(1) >> 1);
    end
    $display("pin end");
  endtask
  // mid-run reset returns the registers to their reset value
  task automatic t_rst;
    @(posedge clk_sys);
    rstn <= 0;
    @(posedge clk_sys);
    rstn <= 1;
    #1 chk("rst outs", 8'h01, outs(1));
    rd(8'h2d, 8'h00);
    rd(8'h2e, 8'h00);
    $display("rst end");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rstn <= 1;
    t_rw;
    t_seq;
    t_pin;
    t_rst;
    complete_run;
  end
  initial begin
    #20us;
    n_mismatch++;
    complete_run;
  end
endmodule
`default_nettype wire
